// ---- rtl/adc_cfg_pkg.sv ----
// Package for the converter configuration write decoder.
// Assumes a single clock domain on clk; serial pins arrive asynchronous.
package adc_cfg_pkg;
  // ******************************************************************
  // Frame layout
  // ******************************************************************
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned HEADER_BITS  = 3;
  localparam int unsigned CTRL_BITS    = 12;
  localparam int unsigned RANGE_BITS   = 8;
  localparam int unsigned SEQ_BITS     = 4;
  localparam int unsigned AUTO_PD_EDGE = 15;

  localparam logic [2:0] HDR_CTRL  = 3'h4;
  localparam logic [2:0] HDR_RANGE = 3'h5;
  localparam logic [2:0] HDR_SEQ   = 3'h7;

  // ******************************************************************
  // Control word fields and reset values
  // ******************************************************************
  localparam int unsigned CW_ADDR_HI  = 11;
  localparam int unsigned CW_ADDR_LO  = 10;
  localparam int unsigned CW_MODE_HI  = 9;
  localparam int unsigned CW_MODE_LO  = 8;
  localparam int unsigned CW_PWR_HI   = 7;
  localparam int unsigned CW_PWR_LO   = 6;
  localparam int unsigned CW_CODING   = 5;
  localparam int unsigned CW_REF      = 4;
  localparam int unsigned CW_SEQ_A    = 3;
  localparam int unsigned CW_SEQ_B    = 2;

  localparam logic [11:0] CTRL_RESET  = 12'h000;
  localparam logic [7:0]  RANGE_RESET = 8'h00;
  localparam logic [3:0]  SEQ_RESET   = 4'h0;

  // Input pairing codes
  localparam logic [1:0] PAIR_SINGLE  = 2'h0;
  localparam logic [1:0] PAIR_PSEUDO2 = 2'h1;
  localparam logic [1:0] PAIR_DIFF2   = 2'h2;
  localparam logic [1:0] PAIR_PSEUDO3 = 2'h3;

  // Negative input select: 0..3 input n, 4 analog ground return
  localparam logic [2:0] NEG_ANALOG_GROUND_RETURN = 3'h4;

  typedef enum logic [1:0] {
    PWR_NORMAL   = 2'h0,
    PWR_STANDBY  = 2'h1,
    PWR_AUTO_OFF = 2'h2,
    PWR_FULL_OFF = 2'h3
  } power_mode_t;

  typedef enum logic [1:0] {
    SEQ_OFF_A  = 2'h0,
    SEQ_LIST   = 2'h1,
    SEQ_UPTO   = 2'h2,
    SEQ_OFF_B  = 2'h3
  } seq_mode_t;
endpackage : adc_cfg_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for one asynchronous pin.
// Assumes the input is a level that may change at any time.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b0  // Level held in both flops during reset
) (
  input  wire logic clk,    // System clock
  input  wire logic reset,  // Synchronous reset
  input  wire logic ce,     // Clock enable
  input  wire logic d,      // Asynchronous input
  output logic      q       // Synchronised level
);
  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      q      <= RESET_VAL;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- rtl/channel_map.sv ----
// Maps channel address and input pairing to the analog input selects.
// Assumes registered inputs; purely combinational.
`timescale 1ns/1ns
`default_nettype none
module channel_map
  import adc_cfg_pkg::*;
(
  input  wire logic [1:0] addr,      // Channel address
  input  wire logic [1:0] pairing,   // Input pairing code
  output logic      [2:0] pos_sel,   // Positive input index
  output logic      [2:0] neg_sel,   // Negative input index or ground
  output logic            invalid    // Selection not allowed
);
  always_comb begin
    pos_sel = {1'b0, addr};
    neg_sel = NEG_ANALOG_GROUND_RETURN;
    invalid = 1'b0;
    unique case (pairing)
      PAIR_PSEUDO3: begin
        neg_sel = 3'h3;
        invalid = (addr == 2'h3);
      end
      PAIR_DIFF2, PAIR_PSEUDO2: begin
        pos_sel = addr[1] ? 3'h2 : 3'h0;
        neg_sel = addr[1] ? 3'h3 : 3'h1;
      end
      PAIR_SINGLE: begin
        pos_sel = {1'b0, addr};
        neg_sel = NEG_ANALOG_GROUND_RETURN;
      end
    endcase
  end
endmodule : channel_map
`default_nettype wire

// ---- rtl/adc_config_write_decoder.sv ----
// Serial write decoder and control word for a four-channel converter.
// Assumes sclk, sdin and cs_n come from the host asynchronously, and that
// the converter core pulses conv_start when it begins a conversion.
`timescale 1ns/1ns
`default_nettype none
module adc_config_write_decoder
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic                  clk,            // System clock, 100 MHz
  input  wire logic                  reset,          // Synchronous reset, active high
  input  wire logic                  ce,             // Clock enable
  input  wire logic                  sclk,           // Serial clock pin
  input  wire logic                  cs_n,           // Frame select pin, active low
  input  wire logic                  sdin,           // Serial data input pin
  input  wire logic                  conv_start,     // Core starts a conversion
  output logic      [11:0]           ctrl_word_q,    // Active control word
  output logic      [1:0]            channel_addr_q, // Channel or last channel
  output logic      [1:0]            pairing_q,      // Input pairing
  output logic      [2:0]            pos_sel_q,      // Positive input index
  output logic      [2:0]            neg_sel_q,      // Negative index, 4 = ground
  output logic                       sel_invalid_q,  // Address invalid in pairing
  output power_mode_t                power_mode_q,   // Power mode
  output logic                       straight_bin_q, // Result in straight binary
  output logic                       int_ref_q,      // Internal reference enable
  output seq_mode_t                  seq_mode_q,     // Sequencer mode
  output logic      [2*CHANNELS-1:0] range_q,        // Two range bits per channel
  output logic      [CHANNELS-1:0]   seq_mask_q,     // Channels in the sequence
  output logic                       powered_down_q, // Circuitry powered down
  output logic                       ref_alive_q,    // Reference kept powered
  output logic                       frame_done_q    // Pulse at frame end
);
  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic sclk_s, cs_n_s, sdin_s;

  // Reset levels match the idle pins, so no false edge follows reset
  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_sync_sclk (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (sclk),
    .q     (sclk_s)
  );

  pin_sync #(
    .RESET_VAL (1'b1)
  ) u_sync_cs (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (cs_n),
    .q     (cs_n_s)
  );

  pin_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_din (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .d     (sdin),
    .q     (sdin_s)
  );

  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_begin;

  // Two flops and the edge register put about three clocks behind each pin edge
  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_prev_q <= 1'b1;
      cs_prev_q   <= 1'b1;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  // Host launches on rising edge, device samples on falling edge
  assign sclk_fall   = sclk_prev_q & ~sclk_s;
  assign sclk_rise   = ~sclk_prev_q & sclk_s;
  assign frame_begin = cs_prev_q & ~cs_n_s;

  // ******************************************************************
  // Frame shifter
  // ******************************************************************
  logic [4:0]  bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic        last_bit;

  // Sampling on the synchronised fall gives the data half a link period to settle
  assign shift_d  = {shift_q[14:0], sdin_s};
  assign last_bit = sclk_fall & ~cs_n_s & (bit_cnt_q == 5'(FRAME_BITS - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 16'h0000;
    end else if (ce) begin
      if (cs_n_s || frame_begin) begin
        // Aborted frames restart cleanly on the next select
        bit_cnt_q <= 5'h00;
      end else if (sclk_fall && bit_cnt_q < 5'(FRAME_BITS)) begin
        // Count stops at sixteen, so overrun clocks never reach last_bit
        bit_cnt_q <= bit_cnt_q + 5'h01;
        shift_q   <= shift_d;
      end
    end
  end

  // ******************************************************************
  // Register decode and load
  // ******************************************************************
  logic [2:0]  header;
  logic [11:0] pending_q;
  logic        pending_vld_q;
  logic        ctrl_wr;
  logic        hdr_arm;

  // Header sits in the top three bits of the full frame
  assign header  = shift_d[15:13];
  assign ctrl_wr = last_bit && header == HDR_CTRL;
  // The header is whole at the third fall, early enough to arm the
  // automatic power modes before the fifteenth rising edge.
  assign hdr_arm = sclk_fall & ~cs_n_s & (bit_cnt_q == 5'(HEADER_BITS - 1))
                   & (shift_d[2:0] == HDR_CTRL);

  always_ff @(posedge clk) begin
    if (reset) begin
      range_q    <= {(2*CHANNELS){1'b0}};
      seq_mask_q <= {CHANNELS{1'b0}};
    end else if (ce && last_bit) begin
      // Header 0xx and 110 fall through and change nothing
      // Range and sequence load at once; only the control word is staged
      unique case (header)
        HDR_RANGE: range_q    <= shift_d[12 -: RANGE_BITS];
        HDR_SEQ:   seq_mask_q <= shift_d[12 -: SEQ_BITS];
        default: ;
      endcase
    end
  end

  // Payload waits in a staging word until the core starts a conversion,
  // so a conversion already running keeps its settings.
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_q     <= CTRL_RESET;
      pending_vld_q <= 1'b0;
      ctrl_word_q   <= CTRL_RESET;
    end else if (ce) begin
      if (ctrl_wr) begin
        // Reserved frame bit 12 is dropped; the word is frame bits 11..0
        pending_q     <= shift_d[CTRL_BITS-1:0];
        pending_vld_q <= 1'b1;
      end else if (conv_start && pending_vld_q) begin
        pending_vld_q <= 1'b0;
      end
      // A write landing with conv_start waits for the following start
      if (conv_start && pending_vld_q && !ctrl_wr) begin
        ctrl_word_q <= pending_q;
      end
    end
  end

  // ******************************************************************
  // Decoded settings
  // ******************************************************************
  logic [2:0] pos_sel;
  logic [2:0] neg_sel;
  logic       sel_invalid;

  // Selection follows the active word, so it too waits for conv_start;
  // the extra flop below keeps every output straight from a register.
  channel_map u_map (
    .addr    (ctrl_word_q[CW_ADDR_HI:CW_ADDR_LO]),
    .pairing (ctrl_word_q[CW_MODE_HI:CW_MODE_LO]),
    .pos_sel (pos_sel),
    .neg_sel (neg_sel),
    .invalid (sel_invalid)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      channel_addr_q <= 2'h0;
      pairing_q      <= PAIR_SINGLE;
      pos_sel_q      <= 3'h0;
      neg_sel_q      <= NEG_ANALOG_GROUND_RETURN;
      sel_invalid_q  <= 1'b0;
      power_mode_q   <= PWR_NORMAL;
      straight_bin_q <= 1'b0;
      int_ref_q      <= 1'b0;
      seq_mode_q     <= SEQ_OFF_A;
    end else if (ce) begin
      channel_addr_q <= ctrl_word_q[CW_ADDR_HI:CW_ADDR_LO];
      pairing_q      <= ctrl_word_q[CW_MODE_HI:CW_MODE_LO];
      pos_sel_q      <= pos_sel;
      neg_sel_q      <= neg_sel;
      sel_invalid_q  <= sel_invalid;
      power_mode_q   <= power_mode_t'(ctrl_word_q[CW_PWR_HI:CW_PWR_LO]);
      // Held for every sequenced channel until a conv_start applies the next control write
      straight_bin_q <= ctrl_word_q[CW_CODING];
      int_ref_q      <= ctrl_word_q[CW_REF];
      seq_mode_q     <= seq_mode_t'(ctrl_word_q[CW_SEQ_A:CW_SEQ_B]);
    end
  end

  // ******************************************************************
  // Power state
  // ******************************************************************
  logic       auto_armed_q;
  logic [1:0] pm_new;
  logic [1:0] pm_mid;
  logic       auto_edge;

  // Control payload is frame bits 11..0, so the finished frame holds the
  // power field where the control word does.
  assign pm_new    = shift_d[CW_PWR_HI:CW_PWR_LO];
  // At the fifteenth rising edge only fifteen bits are in, one place lower
  assign pm_mid    = shift_q[CW_PWR_HI-1:CW_PWR_LO-1];
  assign auto_edge = auto_armed_q & sclk_rise & ~cs_n_s & (bit_cnt_q == 5'(AUTO_PD_EDGE));

  // Auto modes power down on the fifteenth rising edge of a frame that
  // wrote the control word; a new frame select wakes the circuitry.
  // Full shutdown, once conv_start has made it active, is not left on a new select; a normal write ends it, a standby write restores the reference.
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_armed_q   <= 1'b0;
      powered_down_q <= 1'b0;
      ref_alive_q    <= 1'b1;
    end else if (ce) begin
      if (frame_begin) begin
        auto_armed_q <= 1'b0;
        if (power_mode_q != PWR_FULL_OFF) begin
          powered_down_q <= 1'b0;
          ref_alive_q    <= 1'b1;
        end
      end
      if (hdr_arm) begin
        auto_armed_q <= 1'b1;
      end
      if (ctrl_wr && pm_new == PWR_FULL_OFF) begin
        powered_down_q <= 1'b1;
        ref_alive_q    <= 1'b0;
      end else if (ctrl_wr && pm_new == PWR_NORMAL) begin
        powered_down_q <= 1'b0;
        ref_alive_q    <= 1'b1;
      end else if (auto_edge && (pm_mid == PWR_AUTO_OFF || pm_mid == PWR_STANDBY)) begin
        powered_down_q <= 1'b1;
        ref_alive_q    <= (pm_mid == PWR_STANDBY);
      end
    end
  end

  // ******************************************************************
  // Frame completion strobe
  // ******************************************************************
  // No serial output exists, so the registers cannot be read back.
  // Pulse marks every full frame, ignored headers included.
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_done_q <= 1'b0;
    end else if (ce) begin
      frame_done_q <= last_bit;
    end
  end
endmodule : adc_config_write_decoder
`default_nettype wire

// ---- sim/adc_config_write_decoder_assertions.sv ----
// Concurrent checks on the configuration write decoder ports.
// Assumes ce is held high and clk is the only clock domain.
`timescale 1ns/1ns
`default_nettype none
module adc_config_write_decoder_assertions
  import adc_cfg_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input wire logic                  clk,            // System clock
  input wire logic                  reset,          // Synchronous reset
  input wire logic                  conv_start,     // Conversion start
  input wire logic [11:0]           ctrl_word_q,    // Control word
  input wire logic [1:0]            channel_addr_q, // Channel address
  input wire logic [1:0]            pairing_q,      // Input pairing
  input wire logic [2:0]            pos_sel_q,      // Positive input
  input wire logic [2:0]            neg_sel_q,      // Negative input
  input wire logic                  sel_invalid_q,  // Invalid selection
  input wire power_mode_t           power_mode_q,   // Power mode
  input wire logic                  straight_bin_q, // Coding
  input wire logic                  int_ref_q,      // Reference
  input wire seq_mode_t             seq_mode_q,     // Sequencer mode
  input wire logic [2*CHANNELS-1:0] range_q,        // Range bits
  input wire logic [CHANNELS-1:0]   seq_mask_q,     // Sequence mask
  input wire logic                  frame_done_q    // Frame end pulse
);
  // ******************************************************************
  // Helpers and properties
  // ******************************************************************
  logic [11:0] cw_prev_q;
  logic        rst_prev_q;

  // Decoded outputs trail the control word by one clock
  always_ff @(posedge clk) begin
    cw_prev_q  <= ctrl_word_q;
    rst_prev_q <= reset;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_done_pulse; frame_done_q |=> !frame_done_q; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("frame end not one pulse");
  property p_range_hold; !$stable(range_q) |-> frame_done_q; endproperty
  a_range_hold: assert property (p_range_hold)
    else $error("range moved mid-frame");
  property p_seq_hold; !$stable(seq_mask_q) |-> frame_done_q; endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence moved mid-frame");
  property p_ctrl_staged;
    !$stable(ctrl_word_q) |-> $past(conv_start) || $past(conv_start, 2);
  endproperty
  a_ctrl_staged: assert property (p_ctrl_staged) else $error("control word not staged");
  property p_decode;
    !rst_prev_q |-> {channel_addr_q, pairing_q, power_mode_q, straight_bin_q, int_ref_q,
      seq_mode_q} == cw_prev_q[11:2];
  endproperty
  a_decode: assert property (p_decode)
    else $error("decoded fields wrong");
  property p_pseudo3;
    !rst_prev_q && cw_prev_q[9:8] == PAIR_PSEUDO3 |->
      neg_sel_q == 3'h3 && sel_invalid_q == (cw_prev_q[11:10] == 2'h3);
  endproperty
  a_pseudo3: assert property (p_pseudo3) else $error("three pseudo pairing wrong");
  property p_single;
    !rst_prev_q && cw_prev_q[9:8] == PAIR_SINGLE |->
      neg_sel_q == NEG_ANALOG_GROUND_RETURN && pos_sel_q == {1'h0, cw_prev_q[11:10]};
  endproperty
  a_single: assert property (p_single) else $error("single-ended select wrong");
  property p_pairs;
    !rst_prev_q && (cw_prev_q[9] ^ cw_prev_q[8]) |->
      pos_sel_q == {1'h0, cw_prev_q[11], 1'h0} && neg_sel_q == {1'h0, cw_prev_q[11], 1'h1};
  endproperty
  a_pairs: assert property (p_pairs) else $error("pair select wrong");
  property p_reset;
    $fell(reset) |-> ctrl_word_q == CTRL_RESET && range_q == RANGE_RESET &&
      seq_mask_q == SEQ_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
endmodule : adc_config_write_decoder_assertions

bind adc_config_write_decoder adc_config_write_decoder_assertions #(.CHANNELS(CHANNELS)) u_chk (
  .clk(clk), .reset(reset), .conv_start(conv_start), .ctrl_word_q(ctrl_word_q),
  .channel_addr_q(channel_addr_q), .pairing_q(pairing_q), .pos_sel_q(pos_sel_q),
  .neg_sel_q(neg_sel_q), .sel_invalid_q(sel_invalid_q), .power_mode_q(power_mode_q),
  .straight_bin_q(straight_bin_q), .int_ref_q(int_ref_q), .seq_mode_q(seq_mode_q),
  .range_q(range_q), .seq_mask_q(seq_mask_q), .frame_done_q(frame_done_q)
);
`default_nettype wire

// ---- sim/host_serial_model.sv ----
// Host serial controller model driving the decoder's frame pins.
// Assumes clk is the system clock; pins change 1 ns after its edge.
`timescale 1ns/1ns
`default_nettype none
module host_serial_model (
  input  wire logic clk,  // System clock
  output logic      sclk, // Serial clock, idles high
  output logic      cs_n, // Frame select, active low
  output logic      sdin  // Serial data
);
  // ******************************************************************
  // Frame driver
  // ******************************************************************
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdin = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // Short counts abort the frame, long counts pad with toggling data
  task automatic send(input logic [15:0] f, input int n);
    wait_clk(1);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin = (i < 16) ? f[15-i] : ~sdin;
      wait_clk(8);
      sclk = 1'b0;
      wait_clk(8);
      sclk = 1'b1;
    end
    wait_clk(4);
    cs_n = 1'b1;
    // Released line shows the inverse so a held value cannot pass
    sdin = ~sdin;
    wait_clk(6);
  endtask : send
endmodule : host_serial_model
`default_nettype wire

// ---- sim/adc_config_write_decoder_tb.sv ----
// Self-checking bench for the configuration write decoder.
// Assumes the host model drives the serial pins and ce stays high.
`timescale 1ns/1ns
`default_nettype none
module adc_config_write_decoder_tb;
  import adc_cfg_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        conv_start = 1'b0;
  wire         sclk, cs_n, sdin;
  logic [11:0] ctrl_word_q;
  logic [1:0]  channel_addr_q, pairing_q;
  power_mode_t power_mode_q;
  seq_mode_t   seq_mode_q;
  logic [7:0]  range_q;
  logic [3:0]  seq_mask_q;
  logic        straight_bin_q, int_ref_q, powered_down_q, ref_alive_q, frame_done_q;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          frames = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (frame_done_q === 1'b1) frames++;

  host_serial_model host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdin(sdin));
  adc_config_write_decoder #(.CHANNELS(4)) dut (
    .clk(clk), .reset(reset), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .sdin(sdin),
    .conv_start(conv_start), .ctrl_word_q(ctrl_word_q), .channel_addr_q(channel_addr_q),
    .pairing_q(pairing_q), .pos_sel_q(), .neg_sel_q(), .sel_invalid_q(),
    .power_mode_q(power_mode_q), .straight_bin_q(straight_bin_q), .int_ref_q(int_ref_q),
    .seq_mode_q(seq_mode_q), .range_q(range_q), .seq_mask_q(seq_mask_q),
    .powered_down_q(powered_down_q), .ref_alive_q(ref_alive_q), .frame_done_q(frame_done_q)
  );

  // ******************************************************************
  // Tasks and main sequence
  // ******************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ctrl loads after conv_start, decoded fields one clock later
  task automatic convert;
    conv_start = 1'b1;
    tick(1);
    conv_start = 1'b0;
    tick(3);
  endtask : convert

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [2:0]  bad [5];
    logic [11:0] v;
    logic [11:0] prev;
    int          f0;
    bad = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
    prev = 12'h000;
    tick(2);
    reset = 1'b0;
    tick(4);
    chk("ctrl", CTRL_RESET, ctrl_word_q);
    chk("range", 12'(RANGE_RESET), 12'(range_q));
    chk("ref_alive", 12'h001, 12'(ref_alive_q));
    $display("test reset done");
    host.send({3'h5, 8'hb4, 5'h1f}, 16);
    chk("range", 12'h0b4, 12'(range_q));
    host.send({3'h7, 4'ha, 9'h1ff}, 16);
    chk("seq", 12'h00a, 12'(seq_mask_q));
    chk("range", 12'h0b4, 12'(range_q));
    $display("test range and sequence done");
    for (int i = 0; i < 5; i++) begin
      host.send({bad[i], 13'h1fff}, 16);
      chk("range", 12'h0b4, 12'(range_q));
      chk("seq", 12'h00a, 12'(seq_mask_q));
    end
    convert();
    chk("ctrl", 12'h000, ctrl_word_q);
    $display("test ignored headers done");
    f0 = frames;
    host.send({3'h5, 13'h0000}, 10);
    chk("range", 12'h0b4, 12'(range_q));
    chk("frames", 12'(f0), 12'(frames));
    host.send({3'h5, 8'h1e, 5'h00}, 18);
    chk("range", 12'h01e, 12'(range_q));
    chk("frames", 12'(f0 + 1), 12'(frames));
    $display("test abort and overrun done");
    for (int i = 0; i < 16; i++) begin
      v = {i[1:0], i[3:2], i[3:2], i[0], i[1], i[3:2], 2'h0};
      f0 = frames;
      host.send({3'h4, 1'h0, v}, 16);
      chk("frames", 12'(f0 + 1), 12'(frames));
      chk("staged", prev, ctrl_word_q);
      chk("pdown", 12'(i[3:2] != 2'h0), 12'(powered_down_q));
      chk("ref_alive", 12'(!i[3]), 12'(ref_alive_q));
      convert();
      chk("ctrl", v, ctrl_word_q);
      chk("addr", 12'(i[1:0]), 12'(channel_addr_q));
      chk("pairing", 12'(i[3:2]), 12'(pairing_q));
      chk("power", 12'(i[3:2]), 12'(power_mode_q));
      chk("coding", 12'(i[0]), 12'(straight_bin_q));
      chk("ref", 12'(i[1]), 12'(int_ref_q));
      chk("seq_mode", 12'(i[3:2]), 12'(seq_mode_q));
      prev = v;
    end
    $display("test control words done");
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    chk("ctrl", CTRL_RESET, ctrl_word_q);
    chk("range", 12'h000, 12'(range_q));
    chk("seq", 12'h000, 12'(seq_mask_q));
    $display("test second reset done");
    report_and_stop();
  end
endmodule : adc_config_write_decoder_tb
`default_nettype wire
